/* File: core/qdp_core.v */
/*
  quadrature decoder and position counter with avalon-mm registers.
  assumes encoder pins are asynchronous to ref_clk_i; unit_tick_i is a
  one-cycle pulse from logic on ref_clk_i; the bench resolves the
  index and strobe pin levels from the output enables.
*/
// Functional notes
// R1 - source select field picks quadrature, direction, up or down count
// R2 - quadrature mode counts every edge of both channels, four per cycle
// R3 - decoder finds leading channel and keeps direction status bit
// R4 - simultaneous edges on both channels set the phase error flag
// R5 - a then same-sense b is up, opposite down; same channel toggles
// R6 - swap bit exchanges channels before the decoder, reversing count
// R7 - direction mode: a rising edge clocks, b level gives direction
// R8 - up mode counts a rising edges, both edges when both-edge bit set
// R9 - down mode counts a rising edges, both edges when both-edge bit set
// R10 - decoder control bits 8 to 5 invert a, b, index and strobe
// R11 - compare match drives sync pulse on index or strobe pin if enabled
// R12 - up past maximum wraps to zero, down past zero loads maximum, flagged
// R13 - mode 00: index clears forward, loads maximum reverse, next count
// R14 - first count edge after first index edge is the first marker
// R15 - later index resets align to remembered edge, opposite sense reverse
// R16 - index mode latches count and direction at every index marker
// R17 - latched value not zero nor maximum sets error status and flag
// R18 - index mode ignores latch config; errors generated only there
// R19 - mode 01: wrap at maximum and zero with overflow and underflow
// R20 - maximum mode records first marker; latch config 11 uses it
// R21 - mode 10: index reset only on first event, then maximum wrap
// R22 - mode 11: unit tick latches count then resets by direction mode
// R23 - a leading b is forward, b leading a is reverse
// R24 - inputs synchronised, edges by sample compare, updates on clock
// R25 - reset clears count, first marker status and all flags
`timescale 1ns/1ps
`include "qdp_map.vh"

module qdp_core #(
  parameter CNT_W = 32
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [`QDP_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire enc_chan_a_i,
  input wire enc_chan_b_i,
  input wire index_input_i,
  output reg index_out_o,
  output reg index_oe_o,
  input wire strobe_input_i,
  output reg strobe_out_o,
  output reg strobe_oe_o,
  input wire unit_tick_i
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire [3:0] pin_raw = {strobe_input_i, index_input_i, enc_chan_b_i, enc_chan_a_i};
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg [3:0] prev_reg;
  genvar gi;
  // two flops per pin, then a history sample for edges
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge ref_clk_i) begin
        if (rst_i) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          prev_reg[gi] <= 1'b0;
        end else if (ce_i) begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi]; // R24
          prev_reg[gi] <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] dec_ctl_reg;
  reg [15:0] cnt_ctl_reg;
  reg [CNT_W-1:0] pos_reg;
  reg [CNT_W-1:0] max_reg;
  reg [CNT_W-1:0] cmp_reg;
  reg [CNT_W-1:0] idx_lat_reg;
  reg [CNT_W-1:0] tmo_lat_reg;
  reg [15:0] flags_reg;
  reg err_st_reg;
  reg fim_reg;
  reg fid_reg;
  reg ldir_reg;
  reg dir_reg;
  reg last_ch_reg; // 0 = a, 1 = b
  reg last_rise_reg;
  reg mark_ch_reg;
  reg mark_rise_reg;
  reg idx_arm_reg;
  reg idx_done_reg;

  wire [1:0] src = dec_ctl_reg[`QDP_DC_SRC_HI:`QDP_DC_SRC_LO];
  wire [1:0] rmode = cnt_ctl_reg[`QDP_CC_RM_HI:`QDP_CC_RM_LO];
  wire [1:0] index_latch_config = cnt_ctl_reg[`QDP_CC_IEL_HI:`QDP_CC_IEL_LO];

  // ----------------------------------------------------------------
  // polarity and swap
  // ----------------------------------------------------------------
  wire [3:0] inv = {dec_ctl_reg[`QDP_DC_INV_S], dec_ctl_reg[`QDP_DC_INV_I],
                    dec_ctl_reg[`QDP_DC_INV_B], dec_ctl_reg[`QDP_DC_INV_A]};
  wire [3:0] cur_p = sync2_reg ^ inv; // R10
  wire [3:0] old_p = prev_reg ^ inv;
  wire swap = dec_ctl_reg[`QDP_DC_SWAP];
  wire decoder_in_a = swap ? cur_p[1] : cur_p[0]; // R6
  wire decoder_in_b = swap ? cur_p[0] : cur_p[1];
  wire old_a = swap ? old_p[1] : old_p[0];
  wire old_b = swap ? old_p[0] : old_p[1];
  wire edge_a = decoder_in_a ^ old_a; // R24
  wire edge_b = decoder_in_b ^ old_b;
  wire idx_rise = cur_p[2] & ~old_p[2];
  wire idx_fall = ~cur_p[2] & old_p[2];

  // ----------------------------------------------------------------
  // count pulse and direction decode
  // ----------------------------------------------------------------
  reg count_pulse;
  reg decoded_direction;
  reg edge_ch;
  reg edge_rise;
  reg phase_err;
  always @* begin
    count_pulse = 1'b0;
    decoded_direction = dir_reg;
    edge_ch = 1'b0;
    edge_rise = decoder_in_a;
    phase_err = 1'b0;
    case (src) // R1
      `QDP_SRC_QUAD: begin
        if (edge_a & edge_b) begin
          phase_err = 1'b1; // R4
        end else if (edge_a | edge_b) begin
          count_pulse = 1'b1; // R2
          edge_ch = edge_b;
          edge_rise = edge_b ? decoder_in_b : decoder_in_a;
          if (edge_ch == last_ch_reg)
            decoded_direction = ~dir_reg; // R5
          else if (!last_ch_reg)
            decoded_direction = (edge_rise == last_rise_reg); // R5 R23
          else
            decoded_direction = (edge_rise != last_rise_reg); // R5 R23
        end
      end
      `QDP_SRC_DIR: begin
        count_pulse = edge_a & decoder_in_a; // R7
        decoded_direction = decoder_in_b; // R7
      end
      `QDP_SRC_UP: begin
        count_pulse = edge_a & (decoder_in_a | dec_ctl_reg[`QDP_DC_XCR]); // R8
        decoded_direction = 1'b1; // R8
      end
      `QDP_SRC_DOWN: begin
        count_pulse = edge_a & (decoder_in_a | dec_ctl_reg[`QDP_DC_XCR]); // R9
        decoded_direction = 1'b0; // R9
      end
      default: begin
        count_pulse = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // index marker detection
  // ----------------------------------------------------------------
  // first marker: any count edge once armed; later: remembered edge,
  // opposite sense on the same channel when moving in reverse
  wire same_edge = (edge_ch == mark_ch_reg) &&
                   (edge_rise == (decoded_direction ? mark_rise_reg : ~mark_rise_reg));
  wire marker = count_pulse & idx_arm_reg & (~fim_reg | same_edge); // R14 R15
  wire idx_reset = marker & ((rmode == `QDP_RM_INDEX) |
                   ((rmode == `QDP_RM_FIRST) & ~idx_done_reg)); // R13 R21
  wire idx_latch = (rmode == `QDP_RM_INDEX) ? marker :
                   (index_latch_config == `QDP_IEL_MARK) ? marker : // R20
                   (index_latch_config == `QDP_IEL_RISE) ? idx_rise :
                   (index_latch_config == `QDP_IEL_FALL) ? idx_fall : 1'b0; // R18

  // ----------------------------------------------------------------
  // position counter next value
  // ----------------------------------------------------------------
  reg [CNT_W-1:0] pos_next;
  reg ovf;
  reg unf;
  always @* begin
    pos_next = pos_reg;
    ovf = 1'b0;
    unf = 1'b0;
    if ((rmode == `QDP_RM_UTIME) && unit_tick_i) begin
      if (src == `QDP_SRC_UP)
        pos_next = {CNT_W{1'b0}}; // R22
      else if (src == `QDP_SRC_DOWN)
        pos_next = max_reg; // R22
      else
        pos_next = dir_reg ? {CNT_W{1'b0}} : max_reg; // R22
    end else if (idx_reset) begin
      pos_next = decoded_direction ? {CNT_W{1'b0}} : max_reg; // R13 R21
    end else if (count_pulse) begin
      if (decoded_direction) begin
        if (pos_reg == max_reg) begin
          pos_next = {CNT_W{1'b0}}; // R12 R19
          ovf = 1'b1;
        end else begin
          pos_next = pos_reg + 1'b1;
        end
      end else begin
        if (pos_reg == {CNT_W{1'b0}}) begin
          pos_next = max_reg; // R12 R19
          unf = 1'b1;
        end else begin
          pos_next = pos_reg - 1'b1;
        end
      end
    end
  end

  wire cmp_hit = (count_pulse | idx_reset) & (pos_next == cmp_reg) & (pos_next != pos_reg);
  wire lat_err = (pos_reg != {CNT_W{1'b0}}) && (pos_reg != max_reg);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = avs_read_i | avs_write_i;
  wire acc = req & ~avs_waitrequest_o; // transfer completes this edge
  wire wr = acc & avs_write_i;
  wire wr_pos = wr && (avs_address_i == `QDP_OFF_POS_CNT);
  wire wr_flg = wr && (avs_address_i == `QDP_OFF_FLAGS);
  wire [15:0] w1c = wr_flg ? avs_writedata_i[15:0] : 16'h0000;
  reg [15:0] set_fl;
  always @* begin
    set_fl = 16'h0000;
    set_fl[`QDP_FL_PHE] = phase_err; // R4
    set_fl[`QDP_FL_OVF] = ovf; // R12
    set_fl[`QDP_FL_UNF] = unf; // R12
    set_fl[`QDP_FL_PCE] = marker & (rmode == `QDP_RM_INDEX) & lat_err; // R17 R18
    set_fl[`QDP_FL_PCM] = cmp_hit;
  end

  // read mux
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (avs_address_i)
      `QDP_OFF_DEC_CTL: rd_mux[15:0] = dec_ctl_reg;
      `QDP_OFF_CNT_CTL: rd_mux[15:0] = cnt_ctl_reg;
      `QDP_OFF_POS_CNT: rd_mux[CNT_W-1:0] = pos_reg;
      `QDP_OFF_POS_MAX: rd_mux[CNT_W-1:0] = max_reg;
      `QDP_OFF_POS_CMP: rd_mux[CNT_W-1:0] = cmp_reg;
      `QDP_OFF_IDX_LAT: rd_mux[CNT_W-1:0] = idx_lat_reg;
      `QDP_OFF_TMO_LAT: rd_mux[CNT_W-1:0] = tmo_lat_reg;
      `QDP_OFF_STATUS: begin
        rd_mux[`QDP_ST_ERR] = err_st_reg;
        rd_mux[`QDP_ST_FIM] = fim_reg;
        rd_mux[`QDP_ST_FID] = fid_reg;
        rd_mux[`QDP_ST_LDIR] = ldir_reg;
        rd_mux[`QDP_ST_DIR] = dir_reg; // R3
      end
      `QDP_OFF_FLAGS: rd_mux[15:0] = flags_reg;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, then data and release
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end else if (ce_i) begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
      if (req & avs_waitrequest_o)
        avs_readdata_o <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // control registers written by software
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      dec_ctl_reg <= 16'h0000;
      cnt_ctl_reg <= 16'h0000;
      max_reg <= `QDP_RST_MAX;
      cmp_reg <= 32'h00000000;
    end else if (ce_i && wr) begin
      case (avs_address_i)
        `QDP_OFF_DEC_CTL: dec_ctl_reg <= avs_writedata_i[15:0] & 16'hFDE0;
        `QDP_OFF_CNT_CTL: cnt_ctl_reg <= avs_writedata_i[15:0] & 16'h3030;
        `QDP_OFF_POS_MAX: max_reg <= avs_writedata_i[CNT_W-1:0];
        `QDP_OFF_POS_CMP: cmp_reg <= avs_writedata_i[CNT_W-1:0];
        default: cmp_reg <= cmp_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // counter, decoder state, latches and flags
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      pos_reg <= 32'h00000000; // R25
      idx_lat_reg <= 32'h00000000;
      tmo_lat_reg <= 32'h00000000;
      flags_reg <= 16'h0000; // R25
      err_st_reg <= 1'b0;
      fim_reg <= 1'b0; // R25
      fid_reg <= 1'b0;
      ldir_reg <= 1'b0;
      dir_reg <= 1'b1;
      last_ch_reg <= 1'b0;
      last_rise_reg <= 1'b0;
      mark_ch_reg <= 1'b0;
      mark_rise_reg <= 1'b0;
      idx_arm_reg <= 1'b0;
      idx_done_reg <= 1'b0;
    end else if (ce_i) begin
      // software write of the count beats a same-cycle hardware update
      pos_reg <= wr_pos ? avs_writedata_i[CNT_W-1:0] : pos_next; // R24
      // hardware set wins over write-one-to-clear
      flags_reg <= (flags_reg & ~w1c) | set_fl; // R17
      if (count_pulse | (src != `QDP_SRC_QUAD))
        dir_reg <= decoded_direction; // R3
      if (count_pulse) begin
        last_ch_reg <= edge_ch;
        last_rise_reg <= edge_rise;
      end
      if ((rmode == `QDP_RM_UTIME) && unit_tick_i)
        tmo_lat_reg <= pos_reg; // R22
      // index edge arms the next marker
      if (idx_rise | idx_fall)
        idx_arm_reg <= 1'b1;
      else if (marker)
        idx_arm_reg <= 1'b0;
      if (marker & ~fim_reg) begin
        fim_reg <= 1'b1; // R14 R20
        fid_reg <= decoded_direction; // R14
        mark_ch_reg <= edge_ch; // R14
        mark_rise_reg <= decoded_direction ? edge_rise : ~edge_rise;
      end
      if (idx_reset)
        idx_done_reg <= 1'b1; // R21
      if (idx_latch) begin
        idx_lat_reg <= pos_reg; // R16
        ldir_reg <= decoded_direction; // R16
      end
      if (marker && (rmode == `QDP_RM_INDEX))
        err_st_reg <= lat_err; // R17 R18
    end
  end

  // ----------------------------------------------------------------
  // compare sync output
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      index_out_o <= 1'b0;
      index_oe_o <= 1'b0;
      strobe_out_o <= 1'b0;
      strobe_oe_o <= 1'b0;
    end else if (ce_i) begin
      index_oe_o <= dec_ctl_reg[`QDP_DC_SYNC_OUT_ENABLE] & ~dec_ctl_reg[`QDP_DC_SYNC_PIN_SELECT]; // R11
      strobe_oe_o <= dec_ctl_reg[`QDP_DC_SYNC_OUT_ENABLE] & dec_ctl_reg[`QDP_DC_SYNC_PIN_SELECT]; // R11
      index_out_o <= cmp_hit & dec_ctl_reg[`QDP_DC_SYNC_OUT_ENABLE] & ~dec_ctl_reg[`QDP_DC_SYNC_PIN_SELECT];
      strobe_out_o <= cmp_hit & dec_ctl_reg[`QDP_DC_SYNC_OUT_ENABLE] & dec_ctl_reg[`QDP_DC_SYNC_PIN_SELECT];
    end
  end

endmodule // qdp_core

/* File: inc/qdp_map.vh */
/*
  register offsets, field positions, reset values and mode codes
  of the quadrature decoder / position counter.
  assumes byte addressing on a 32-bit avalon-mm bus.
*/
`ifndef QDP_MAP_VH
`define QDP_MAP_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define QDP_ADDR_W 6
`define QDP_OFF_DEC_CTL 6'h00
`define QDP_OFF_CNT_CTL 6'h04
`define QDP_OFF_POS_CNT 6'h08
`define QDP_OFF_POS_MAX 6'h0C
`define QDP_OFF_POS_CMP 6'h10
`define QDP_OFF_IDX_LAT 6'h14
`define QDP_OFF_TMO_LAT 6'h18
`define QDP_OFF_STATUS 6'h1C
`define QDP_OFF_FLAGS 6'h20
// ----------------------------------------------------------------
// decoder_control fields
// ----------------------------------------------------------------
`define QDP_DC_SRC_HI 15
`define QDP_DC_SRC_LO 14
`define QDP_DC_SYNC_OUT_ENABLE 13
`define QDP_DC_SYNC_PIN_SELECT 12
`define QDP_DC_XCR 11
`define QDP_DC_SWAP 10
`define QDP_DC_INV_A 8
`define QDP_DC_INV_B 7
`define QDP_DC_INV_I 6
`define QDP_DC_INV_S 5
// ----------------------------------------------------------------
// counter_control fields
// ----------------------------------------------------------------
`define QDP_CC_RM_HI 13
`define QDP_CC_RM_LO 12
`define QDP_CC_IEL_HI 5
`define QDP_CC_IEL_LO 4
// ----------------------------------------------------------------
// status and flag bit positions
// ----------------------------------------------------------------
`define QDP_ST_ERR 0
`define QDP_ST_FIM 1
`define QDP_ST_FID 2
`define QDP_ST_LDIR 3
`define QDP_ST_DIR 5
`define QDP_FL_PCE 1
`define QDP_FL_PHE 2
`define QDP_FL_UNF 5
`define QDP_FL_OVF 6
`define QDP_FL_PCM 11
// ----------------------------------------------------------------
// mode codes and reset values
// ----------------------------------------------------------------
`define QDP_SRC_QUAD 2'h0
`define QDP_SRC_DIR 2'h1
`define QDP_SRC_UP 2'h2
`define QDP_SRC_DOWN 2'h3
`define QDP_RM_INDEX 2'h0
`define QDP_RM_MAX 2'h1
`define QDP_RM_FIRST 2'h2
`define QDP_RM_UTIME 2'h3
`define QDP_IEL_RISE 2'h1
`define QDP_IEL_FALL 2'h2
`define QDP_IEL_MARK 2'h3
`define QDP_RST_MAX 32'hFFFFFFFF
`endif

/* File: sim/qdp_core_props.sv */
/*
  checker for qdp_core: bus handshake, reset state and sync output.
  assumes ce_i is held high and sees only the ports of qdp_core.
*/
`timescale 1ns/1ps
`include "qdp_map.vh"
module qdp_core_props #(
  parameter CNT_W = 32
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [`QDP_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire enc_chan_a_i,
  input wire enc_chan_b_i,
  input wire index_input_i,
  input wire index_out_o,
  input wire index_oe_o,
  input wire strobe_input_i,
  input wire strobe_out_o,
  input wire strobe_oe_o,
  input wire unit_tick_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire wr_ack = avs_write_i && !avs_waitrequest_o;
  reg [31:0] dc_reg;
  reg [31:0] max_reg;
  reg [1:0] age_reg;
  reg [3:0] quiet_reg;
  reg a_reg;
  reg b_reg;
  // shadow of control writes and a quiet-time counter
  always @(posedge ref_clk_i) begin
    a_reg <= enc_chan_a_i;
    b_reg <= enc_chan_b_i;
    if (rst_i || a_reg != enc_chan_a_i || b_reg != enc_chan_b_i || avs_write_i || unit_tick_i)
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF)
      quiet_reg <= quiet_reg + 4'h1;
    if (rst_i) begin
      dc_reg <= 32'h0;
      max_reg <= `QDP_RST_MAX;
      age_reg <= 2'h0;
    end else begin
      if (wr_ack && avs_address_i == `QDP_OFF_DEC_CTL) begin
        dc_reg <= avs_writedata_i;
        age_reg <= 2'h0;
      end else if (age_reg != 2'h3)
        age_reg <= age_reg + 2'h1;
      if (wr_ack && avs_address_i == `QDP_OFF_POS_MAX)
        max_reg <= avs_writedata_i;
    end
  end
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ans;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("waitrequest answer not one cycle");
  a_idle_wait: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest dropped while idle");
  a_reset_quiet: assert property ($past(rst_i) |-> avs_waitrequest_o && avs_readdata_o == 32'h0 && !index_oe_o && !strobe_oe_o && !index_out_o)
    else $error("outputs not cleared by reset");
  a_unmapped_zero: assert property (s_req ##0 avs_read_i && avs_address_i > 6'h20 |=> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_max_readback: assert property (s_req ##0 avs_read_i && avs_address_i == `QDP_OFF_POS_MAX |=> avs_readdata_o == max_reg)
    else $error("maximum register readback wrong");
  a_oe_select: assert property (age_reg == 2'h3 |-> index_oe_o == (dc_reg[13] && !dc_reg[12]) && strobe_oe_o == (dc_reg[13] && dc_reg[12]))
    else $error("sync output enable wrong");
  a_index_pulse: assert property (index_out_o |=> !index_out_o)
    else $error("index sync pulse too long");
  a_strobe_pulse: assert property (strobe_out_o |=> !strobe_out_o)
    else $error("strobe sync pulse too long");
  a_quiet_pulse: assert property (quiet_reg == 4'hF |-> !index_out_o && !strobe_out_o)
    else $error("sync pulse without count change");
endmodule // qdp_core_props

bind qdp_core qdp_core_props #(.CNT_W(CNT_W)) u_props (.ref_clk_i, .rst_i, .ce_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
  .enc_chan_a_i, .enc_chan_b_i, .index_input_i, .index_out_o, .index_oe_o,
  .strobe_input_i, .strobe_out_o, .strobe_oe_o, .unit_tick_i);

/* File: sim/qdp_enc_model.sv */
/*
  encoder model: quadrature or clock/direction pins and an index line.
  assumes the bench calls its tasks and resolves the shared index pin.
*/
`timescale 1ns/1ps
module qdp_enc_model (
  input wire ref_clk_i,
  output logic enc_a_o,
  output logic enc_b_o,
  output logic index_o
);
  logic [1:0] ph_reg = 2'h0;
  initial begin
    enc_a_o = 1'h0;
    enc_b_o = 1'h0;
    index_o = 1'h0;
  end
  // quarter steps, a leads b when forward
  task step(input logic fwd, input int n, input int gap);
    logic [1:0] p;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_i);
      p = fwd ? ph_reg + 2'h1 : ph_reg - 2'h1;
      ph_reg <= p;
      enc_a_o <= p[1] ^ p[0];
      enc_b_o <= p[1];
      repeat (gap) @(posedge ref_clk_i);
    end
  endtask
  // raw pin levels, may move both at once
  task pins(input logic a, input logic b);
    @(posedge ref_clk_i);
    enc_a_o <= a;
    enc_b_o <= b;
    ph_reg <= {b, a ^ b};
    repeat (6) @(posedge ref_clk_i);
  endtask
  task idx(input logic v);
    @(posedge ref_clk_i);
    index_o <= v;
    repeat (6) @(posedge ref_clk_i);
  endtask
endmodule // qdp_enc_model

/* File: sim/qdp_core_tb_top.sv */
/*
  self-checking bench for qdp_core over avalon-mm.
  assumes qdp_enc_model drives the encoder pins; ce_i held high.
*/
`timescale 1ns/1ps
`include "qdp_map.vh"
module qdp_core_tb_top;
  logic ref_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic ce_i = 1'h1;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic unit_tick_i = 1'h0;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, index_out_o, index_oe_o, strobe_out_o, strobe_oe_o;
  wire enc_a, enc_b, idx_drv;
  // shared pins: design drives when enabled, else the index sensor or a low strobe level
  wire index_pin = index_oe_o ? index_out_o : idx_drv;
  wire strobe_pin = strobe_oe_o ? strobe_out_o : 1'h0;
  integer fail_count = 0;
  integer check_count = 0;
  integer idx_pulses = 0;
  integer stb_pulses = 0;
  logic [31:0] rd;
  qdp_core uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .enc_chan_a_i(enc_a), .enc_chan_b_i(enc_b),
    .index_input_i(index_pin), .index_out_o(index_out_o), .index_oe_o(index_oe_o),
    .strobe_input_i(strobe_pin), .strobe_out_o(strobe_out_o), .strobe_oe_o(strobe_oe_o),
    .unit_tick_i(unit_tick_i));
  qdp_enc_model enc (.ref_clk_i(ref_clk_i), .enc_a_o(enc_a), .enc_b_o(enc_b), .index_o(idx_drv));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  // count sync pulses per pin
  always @(posedge ref_clk_i) begin
    if (index_out_o === 1'h1) idx_pulses <= idx_pulses + 1;
    if (strobe_out_o === 1'h1) stb_pulses <= stb_pulses + 1;
  end
  task end_of_test;
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer, held until waitrequest is sampled low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    rd = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task rchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task tick;
    @(posedge ref_clk_i);
    unit_tick_i <= 1'h1;
    @(posedge ref_clk_i);
    unit_tick_i <= 1'h0;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    rchk(`QDP_OFF_POS_CNT, 32'h0);
    rchk(`QDP_OFF_POS_MAX, 32'hFFFFFFFF);
    rchk(`QDP_OFF_STATUS, 32'h20);
    rchk(`QDP_OFF_FLAGS, 32'h0);
    rchk(6'h24, 32'h0);
    wr(`QDP_OFF_POS_CMP, 32'h1000);
    wr(`QDP_OFF_CNT_CTL, 32'h1000);
    enc.step(1'h1, 2, 6);
    wr(`QDP_OFF_POS_CNT, 32'h0);
    wr(`QDP_OFF_FLAGS, 32'h0000FFFF);
    enc.step(1'h1, 8, 25);
    rchk(`QDP_OFF_POS_CNT, 32'h8);
    rchk(`QDP_OFF_STATUS, 32'h20);
    enc.step(1'h0, 4, 6);
    rchk(`QDP_OFF_POS_CNT, 32'h4);
    rchk(`QDP_OFF_STATUS, 32'h0);
    wr(`QDP_OFF_DEC_CTL, 32'h400);
    enc.step(1'h1, 4, 6);
    rchk(`QDP_OFF_POS_CNT, 32'h0);
    wr(`QDP_OFF_DEC_CTL, 32'h0);
    enc.pins(1'h0, 1'h0);
    rchk(`QDP_OFF_FLAGS, 32'h4);
    rchk(`QDP_OFF_POS_CNT, 32'h0);
    wr(`QDP_OFF_FLAGS, 32'h4);
    rchk(`QDP_OFF_FLAGS, 32'h0);
    enc.step(1'h1, 2, 6);
    wr(`QDP_OFF_POS_MAX, 32'h5);
    wr(`QDP_OFF_POS_CNT, 32'h5);
    enc.step(1'h1, 1, 6);
    rchk(`QDP_OFF_POS_CNT, 32'h0);
    rchk(`QDP_OFF_FLAGS, 32'h40);
    enc.step(1'h0, 1, 6);
    rchk(`QDP_OFF_POS_CNT, 32'h5);
    rchk(`QDP_OFF_FLAGS, 32'h60);
    wr(`QDP_OFF_FLAGS, 32'h60);
    wr(`QDP_OFF_POS_MAX, 32'hFFFFFFFF);
    wr(`QDP_OFF_DEC_CTL, 32'h4000);
    // clock on a, direction on b
    for (int k = 0; k < 6; k++) enc.pins(k[0], k < 4);
    rchk(`QDP_OFF_POS_CNT, 32'h6);
    for (int k = 0; k < 4; k++) begin
      wr(`QDP_OFF_DEC_CTL, {16'h0, 1'h1, k[0], 2'h0, k[1], 11'h0});
      wr(`QDP_OFF_POS_CNT, 32'h100);
      for (int j = 0; j < 4; j++) enc.pins(j[0], 1'h0);
      rchk(`QDP_OFF_POS_CNT, k[0] ? 32'h100 - (k[1] ? 32'h4 : 32'h2) : 32'h100 + (k[1] ? 32'h4 : 32'h2));
    end
    wr(`QDP_OFF_DEC_CTL, 32'h8100);
    wr(`QDP_OFF_POS_CNT, 32'h100);
    enc.pins(1'h0, 1'h0);
    rchk(`QDP_OFF_POS_CNT, 32'h101);
    enc.pins(1'h1, 1'h0);
    rchk(`QDP_OFF_POS_CNT, 32'h101);
    wr(`QDP_OFF_DEC_CTL, 32'h3000);
    enc.step(1'h1, 2, 6);
    wr(`QDP_OFF_POS_CNT, 32'hFFE);
    enc.step(1'h1, 3, 6);
    rchk(`QDP_OFF_FLAGS, 32'h800);
    chk(stb_pulses, 32'h1);
    chk(idx_pulses, 32'h0);
    wr(`QDP_OFF_DEC_CTL, 32'h0);
    wr(`QDP_OFF_FLAGS, 32'h800);
    wr(`QDP_OFF_CNT_CTL, 32'h0);
    wr(`QDP_OFF_POS_CNT, 32'h3);
    enc.idx(1'h1);
    enc.step(1'h1, 1, 6);
    rchk(`QDP_OFF_POS_CNT, 32'h0);
    rchk(`QDP_OFF_IDX_LAT, 32'h3);
    rchk(`QDP_OFF_STATUS, 32'h2F);
    rchk(`QDP_OFF_FLAGS, 32'h2);
    // second index: reset only on the remembered a falling edge
    wr(`QDP_OFF_POS_CNT, 32'h10);
    enc.idx(1'h0);
    enc.step(1'h1, 4, 6);
    rchk(`QDP_OFF_POS_CNT, 32'h0);
    rchk(`QDP_OFF_IDX_LAT, 32'h13);
    wr(`QDP_OFF_CNT_CTL, 32'h3000);
    wr(`QDP_OFF_POS_CNT, 32'h7);
    tick;
    rchk(`QDP_OFF_TMO_LAT, 32'h7);
    rchk(`QDP_OFF_POS_CNT, 32'h0);
    wr(`QDP_OFF_DEC_CTL, 32'hC000);
    wr(`QDP_OFF_POS_CNT, 32'h3);
    tick;
    rchk(`QDP_OFF_TMO_LAT, 32'h3);
    rchk(`QDP_OFF_POS_CNT, 32'hFFFFFFFF);
    // compare sync pulse on the index pin
    wr(`QDP_OFF_DEC_CTL, 32'h2000);
    wr(`QDP_OFF_POS_CMP, 32'h5);
    wr(`QDP_OFF_POS_CNT, 32'h4);
    enc.step(1'h1, 1, 6);
    chk(idx_pulses, 32'h1);
    chk(stb_pulses, 32'h1);
    end_of_test;
  end
  // watchdog against a run that never reaches end_of_test; bus gives up on its own after 50 cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count = fail_count + 1;
    end_of_test;
  end
endmodule // qdp_core_tb_top
